// ### inc/dfa_pkg.sv
// Purpose: shared constants and types of the drive fault annunciator
// Assumes: 20 MHz system clock, one lamp tick per half period of the 2 Hz flash
// Notes:   entry codes are the history and lamp pulse numbering
package dfa_pkg;

  // clock and lamp timing
  localparam int unsigned CLK_HZ   = 20_000_000;
  localparam int unsigned TICK_MS  = 250;                      // half period of 2 Hz
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;  // 5,000,000 cycles
  localparam int unsigned PAUSE_MS = 2000;                     // dark gap between bursts
  localparam int unsigned HOLD_MS  = 2000;                     // confirm key hold time
  localparam logic [3:0]  PAUSE_TICKS = 4'(PAUSE_MS / TICK_MS);
  localparam logic [3:0]  HOLD_TICKS  = 4'(HOLD_MS / TICK_MS);
  localparam logic [3:0]  CHECK_TICKS = 4'h4;                  // power-up self check, 1 s
  localparam int unsigned HIST_DEPTH  = 8;
  localparam logic [1:0]  KP_LAST     = 2'h3;                  // newest plus three older

  // history entries; fault entries equal their lamp pulse count
  typedef logic [3:0] entry_t;
  localparam entry_t E_NONE  = 4'h0;
  localparam entry_t E_OVLD  = 4'h1;
  localparam entry_t E_EXT   = 4'h2;
  localparam entry_t E_OVOLT = 4'h3;
  localparam entry_t E_OCUR  = 4'h4;
  localparam entry_t E_OTEMP = 4'h5;
  localparam entry_t E_UVOLT = 4'h6;
  localparam entry_t E_DEFS  = 4'h7;   // defaults_restored_entry

  // serial link codes
  localparam logic [7:0] MB_NONE  = 8'h00;
  localparam logic [7:0] MB_OVLD  = 8'h04;
  localparam logic [7:0] MB_EXT   = 8'h0B;
  localparam logic [7:0] MB_OVOLT = 8'h06;
  localparam logic [7:0] MB_OCUR  = 8'h03;
  localparam logic [7:0] MB_OTEMP = 8'h08;
  localparam logic [7:0] MB_UVOLT = 8'hF0;
  localparam logic [7:0] MB_DEFS  = 8'hF1;

  typedef struct packed {
    logic overload;
    logic external;
    logic overvolt;
    logic overcur;
    logic overtemp;
  } mon_t;

  typedef struct packed {
    logic drive_enable_cmd;
    logic key_ok;
    logic key_up;
    logic key_stop;
  } pins_t;

  typedef struct packed {
    logic run;
    logic state;
    logic fault;
  } lamps_t;

  typedef enum logic [1:0] {BS_ON, BS_OFF, BS_PAUSE} burst_t;

  // entry to serial link code, used for live fault and history
  function automatic logic [7:0] mb_code(input entry_t e);
    case (e)
      E_OVLD:  mb_code = MB_OVLD;
      E_EXT:   mb_code = MB_EXT;
      E_OVOLT: mb_code = MB_OVOLT;
      E_OCUR:  mb_code = MB_OCUR;
      E_OTEMP: mb_code = MB_OTEMP;
      E_UVOLT: mb_code = MB_UVOLT;
      E_DEFS:  mb_code = MB_DEFS;
      default: mb_code = MB_NONE;
    endcase
  endfunction : mb_code

endpackage : dfa_pkg

// ### verilog/dfa_tick_div.sv
// Purpose: lamp tick divider, one-cycle enable every TICK_CYCLES clocks
// Assumes: TICK_CYCLES of at least 2
// Notes:   simulation may shorten the period through the parameter
`timescale 1ns/1ps
module dfa_tick_div #(
  parameter int unsigned TICK_CYCLES = dfa_pkg::TICK_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);
  import dfa_pkg::*;

  localparam int unsigned W = $clog2(TICK_CYCLES);
  localparam logic [W-1:0] LAST = W'(TICK_CYCLES - 1);

  logic [W-1:0] cnt_reg;
  logic         wrap;

  assign wrap   = (cnt_reg == LAST);
  assign tick_o = wrap;

  // free running counter, no clock gating
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt_reg <= '0;
    else          cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
  end

endmodule : dfa_tick_div

// ### verilog/dfa_fault_log.sv
// Purpose: fault history, newest at index zero, older entries shift down
// Assumes: push is a one-cycle pulse
// Notes:   there is no clear input; only power-on reset empties it
`timescale 1ns/1ps
module dfa_fault_log #(
  parameter int unsigned DEPTH = dfa_pkg::HIST_DEPTH
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     push_i,
  input  wire dfa_pkg::entry_t          entry_i,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
  input  wire logic [1:0]               kp_idx_i,
  output dfa_pkg::entry_t               rd_data_o,
  output dfa_pkg::entry_t               kp_data_o
);
  import dfa_pkg::*;

  localparam int unsigned IW = $clog2(DEPTH);

  entry_t hist_reg [DEPTH];

  // shift chain; no path clears it, defaults restore included
  for (genvar g = 0; g < DEPTH; g++) begin : g_hist
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)    hist_reg[g] <= E_NONE;
      else if (push_i) hist_reg[g] <= (g == 0) ? entry_i : hist_reg[(g == 0) ? 0 : g - 1];
    end
  end

  // registered read ports for link and keypad
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= E_NONE;
      kp_data_o <= E_NONE;
    end else begin
      rd_data_o <= hist_reg[rd_idx_i];
      kp_data_o <= hist_reg[IW'(kp_idx_i)];
    end
  end

endmodule : dfa_fault_log

// ### verilog/dfa_annunciator.sv
// Purpose: fault supervision, lamp annunciation, reset sources and history
// Assumes: monitor inputs come from logic on clk_i; pins_i are asynchronous
// Notes:   flashing steps only on the 250 ms tick; a change of lamp mode or run state shows on the next clock
`timescale 1ns/1ps
module dfa_annunciator #(
  parameter int unsigned TICK_CYCLES = dfa_pkg::TICK_CYC,
  parameter int unsigned HIST_DEPTH  = dfa_pkg::HIST_DEPTH
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire dfa_pkg::mon_t                 mon_i,
  input  wire logic                          undervolt_i,
  input  wire logic                          cpu_fault_i,
  input  wire dfa_pkg::pins_t                pins_i,
  input  wire logic                          bus_reset_i,
  input  wire logic                          defaults_restore_i,
  input  wire logic                          auto_restart_i,
  input  wire logic [$clog2(HIST_DEPTH)-1:0] hist_idx_i,
  output logic                               drive_run_o,
  output logic                               relay_closed_o,
  output dfa_pkg::lamps_t                    lamps_o,
  output dfa_pkg::entry_t                    fault_num_o,
  output logic [7:0]                         fault_mb_o,
  output dfa_pkg::entry_t                    hist_data_o,
  output logic [7:0]                         hist_mb_o,
  output logic                               kp_param_mode_o,
  output logic                               kp_digit_flash_o,
  output logic                               kp_hist_view_o,
  output dfa_pkg::entry_t                    kp_entry_o,
  output logic [2:0]                         kp_dp_o
);
  import dfa_pkg::*;

  // pin synchronisers and edge history
  pins_t  s1_reg;
  pins_t  s2_reg;
  pins_t  prev_reg;
  logic   tick;
  logic   uv_prev_reg;

  // fault state
  entry_t fault_reg;
  entry_t fault_next;
  entry_t mon_entry;
  logic   any_mon;
  logic   new_fault;
  logic   clear_req;
  logic   fault_on;

  // lamp sequencing
  burst_t     st_reg;
  burst_t     st_next;
  entry_t     pulse_reg;
  entry_t     pulse_next;
  logic [3:0] pause_reg;
  logic [3:0] pause_next;
  logic       blink_reg;
  logic [3:0] start_reg;
  logic       start_busy;
  logic       burst_lamp;
  lamps_t     lamps_next;
  logic       run_next;

  // keypad
  logic [3:0] hold_reg;
  logic       param_reg;
  logic       view_reg;
  logic [1:0] kp_idx_reg;

  // history feed
  logic   en_rise;
  logic   stop_rise;
  logic   ok_rise;
  logic   up_rise;
  logic   uv_rise;
  logic   push;
  entry_t push_entry;

  // two flops before any logic sees a pin
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      prev_reg <= '0;
    end else begin
      s1_reg   <= pins_i;
      s2_reg   <= s1_reg;
      prev_reg <= s2_reg;
    end
  end

  // edges, pins taken on the second flop only; undervoltage taken on its input
  assign en_rise   = s2_reg.drive_enable_cmd & ~prev_reg.drive_enable_cmd;
  assign stop_rise = s2_reg.key_stop & ~prev_reg.key_stop;
  assign ok_rise   = s2_reg.key_ok & ~prev_reg.key_ok;
  assign up_rise   = s2_reg.key_up & ~prev_reg.key_up;
  assign uv_rise   = undervolt_i & ~uv_prev_reg;

  dfa_tick_div #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick_o  (tick)
  );

  // monitor to fault number; lowest number wins a tie
  assign any_mon   = |mon_i;
  assign mon_entry = mon_i.overload ? E_OVLD  :
                     mon_i.external ? E_EXT   :
                     mon_i.overvolt ? E_OVOLT :
                     mon_i.overcur  ? E_OCUR  :
                     mon_i.overtemp ? E_OTEMP : E_NONE;

  // enable toggle, stop key and link clear faults; power cycle is reset
  // auto clear only when restart mode allows it
  assign clear_req = en_rise | stop_rise | bus_reset_i | (auto_restart_i & ~any_mon);
  assign new_fault = any_mon & (fault_reg == E_NONE);
  assign fault_on  = (fault_reg != E_NONE);

  // a live monitor blocks the clear, so a set in the clear cycle wins
  assign fault_next = new_fault              ? mon_entry :
                      (clear_req & ~any_mon) ? E_NONE    :
                      fault_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) fault_reg <= E_NONE;
    else          fault_reg <= fault_next;
  end

  // 2 Hz flash base, toggles every 250 ms tick
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)  blink_reg <= 1'b1;
    else if (tick) blink_reg <= ~blink_reg;
  end

  // power-up or mains return check, restarted by undervoltage
  assign start_busy = (start_reg < CHECK_TICKS);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)                start_reg <= '0;
    else if (undervolt_i)        start_reg <= '0;
    else if (tick && start_busy) start_reg <= start_reg + 4'h1;
  end

  // burst sequencer: N on/off pairs, then eight dark ticks
  always_comb begin
    st_next    = st_reg;
    pulse_next = pulse_reg;
    pause_next = pause_reg;
    if (!fault_on) begin
      st_next    = BS_ON;
      pulse_next = E_OVLD;
      pause_next = '0;
    end else if (tick) begin
      case (st_reg)
        BS_ON: begin
          st_next = BS_OFF;
        end
        BS_OFF: begin
          if (pulse_reg >= fault_reg) begin // count equals fault number
            st_next    = BS_PAUSE;
            pause_next = '0;
          end else begin
            st_next    = BS_ON;
            pulse_next = pulse_reg + 4'h1;
          end
        end
        BS_PAUSE: begin
          if (pause_reg == PAUSE_TICKS - 4'h1) begin
            st_next    = BS_ON;
            pulse_next = E_OVLD;
          end else begin
            pause_next = pause_reg + 4'h1;
          end
        end
        default: begin
          st_next = BS_ON;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg    <= BS_ON;
      pulse_reg <= E_OVLD;
      pause_reg <= '0;
    end else begin
      st_reg    <= st_next;
      pulse_reg <= pulse_next;
      pause_reg <= pause_next;
    end
  end

  assign burst_lamp = fault_on & (st_reg == BS_ON);

  // level enable is enough, no fresh edge needed after a clear
  assign run_next = s2_reg.drive_enable_cmd & ~fault_on & ~undervolt_i
                  & ~cpu_fault_i & ~start_busy;

  // lamp priority: processor, mains, self check, fault, normal
  always_comb begin
    lamps_next = '0;
    if (cpu_fault_i) begin
      lamps_next = '{run: 1'b0, state: 1'b1, fault: 1'b1};
    end else if (undervolt_i || start_busy) begin
      lamps_next = '{run: 1'b0, state: blink_reg, fault: blink_reg};
    end else if (fault_on) begin
      lamps_next = '{run: 1'b0, state: 1'b1, fault: burst_lamp};
    end else begin
      lamps_next = '{run: drive_run_o | blink_reg, state: 1'b0, fault: 1'b0};
    end
  end

  // outputs from flops; relay opens on fault or processor fault
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_run_o    <= 1'b0;
      relay_closed_o <= 1'b0;
      lamps_o        <= '0;
      fault_mb_o     <= MB_NONE;
      uv_prev_reg    <= 1'b0;
    end else begin
      drive_run_o    <= run_next;
      relay_closed_o <= ~fault_on & ~cpu_fault_i;
      lamps_o        <= lamps_next;
      fault_mb_o     <= mb_code(fault_reg);
      uv_prev_reg    <= undervolt_i;
    end
  end

  assign fault_num_o = fault_reg;

  // history feed; in a clash only one entry is logged: defaults restore, then new fault, then undervoltage
  assign push       = new_fault | uv_rise | defaults_restore_i;
  assign push_entry = defaults_restore_i ? E_DEFS :
                      new_fault          ? mon_entry : E_UVOLT;

  dfa_fault_log #(
    .DEPTH (HIST_DEPTH)
  ) u_log (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .push_i    (push),
    .entry_i   (push_entry),
    .rd_idx_i  (hist_idx_i),
    .kp_idx_i  (kp_idx_reg),
    .rd_data_o (hist_data_o),
    .kp_data_o (kp_entry_o)
  );

  assign hist_mb_o = mb_code(hist_data_o);

  // confirm key hold timer, counted in lamp ticks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)                    hold_reg <= '0;
    else if (!s2_reg.key_ok)         hold_reg <= '0;
    else if (tick && !(hold_reg == HOLD_TICKS)) hold_reg <= hold_reg + 4'h1;
  end

  // parameter mode, then history view on a further confirm press
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      param_reg  <= 1'b0;
      view_reg   <= 1'b0;
      kp_idx_reg <= '0;
    end else if (stop_rise) begin
      param_reg  <= 1'b0;
      view_reg   <= 1'b0;
      kp_idx_reg <= '0;
    end else if (!param_reg) begin
      param_reg  <= (hold_reg == HOLD_TICKS);
    end else if (!view_reg) begin
      view_reg   <= ok_rise;
      kp_idx_reg <= '0;
    end else if (up_rise && kp_idx_reg != KP_LAST) begin
      kp_idx_reg <= kp_idx_reg + 2'h1;
    end
  end

  // flashing points show age: none, one, two or three
  assign kp_param_mode_o  = param_reg;
  assign kp_hist_view_o   = view_reg;
  assign kp_digit_flash_o = param_reg & ~view_reg & blink_reg;
  assign kp_dp_o = view_reg & blink_reg ? 3'((4'h1 << kp_idx_reg) - 4'h1) : 3'h0;

  // ---- checks ----
  sequence s_burst_end;
    st_reg == BS_OFF && tick && pulse_reg >= fault_reg;
  endsequence

  a_fault_relay_open: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fault_on |=> !relay_closed_o && !drive_run_o)
    else $error("relay closed or drive running during fault");

  a_burst_to_pause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fault_on ##0 s_burst_end |=> st_reg == BS_PAUSE ##0 !burst_lamp)
    else $error("burst did not stop at fault count");

  a_pulse_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fault_on |-> pulse_reg <= fault_reg)
    else $error("pulse count passed fault number");

  a_uv_flash: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    undervolt_i && !cpu_fault_i |=> !lamps_o.run && lamps_o.state == lamps_o.fault)
    else $error("undervoltage lamps wrong");

  a_startup_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start_busy |=> !drive_run_o && !lamps_o.run)
    else $error("run during power-up check");

  a_cpu_steady: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cpu_fault_i |=> lamps_o == 3'b011)
    else $error("processor fault lamps wrong");

  a_no_self_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fault_on && !auto_restart_i && !en_rise && !stop_rise && !bus_reset_i
    |=> $stable(fault_reg))
    else $error("fault cleared without reset");

  a_stop_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fault_on && stop_rise && !any_mon |=> !fault_on)
    else $error("stop key did not clear fault");

  a_ocur_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fault_reg == E_OCUR |=> fault_mb_o == 8'h03)
    else $error("overcurrent link code wrong");

  // one press moves exactly one step; a held key must not keep stepping
  a_kp_up_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    view_reg && up_rise && !stop_rise && kp_idx_reg < KP_LAST
    |=> kp_idx_reg == $past(kp_idx_reg) + 2'h1
    ##1 (kp_idx_reg == $past(kp_idx_reg) || !view_reg))
    else $error("history view step wrong");

  a_defs_logged: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    defaults_restore_i |=> u_log.hist_reg[0] == E_DEFS)
    else $error("defaults entry missing");

endmodule : dfa_annunciator

// ### dv/dfa_partner.sv
// Purpose: operator keypad, enable input and link master beside the annunciator
// Assumes: it changes its pins only on the falling clock edge
// Notes:   keys are held for several clocks, as a finger would hold them
`timescale 1ns/1ps
module dfa_partner (
  input  wire logic      clk_i,
  output dfa_pkg::pins_t pins_o,
  output logic           bus_reset_o
);
  import dfa_pkg::*;

  // enable high from power-up, as if tied to the control supply; only toggle_enable drops it
  initial begin
    pins_o                  = '0;
    pins_o.drive_enable_cmd = 1'b1;
    bus_reset_o             = 1'b0;
  end

  // key held for cyc clocks; the release gap lets the synchroniser see it
  task automatic press(input int key, input int cyc);
    @(negedge clk_i);
    case (key)
      0: pins_o.key_ok = 1'b1;
      1: pins_o.key_up = 1'b1;
      default: pins_o.key_stop = 1'b1;
    endcase
    repeat (cyc) @(negedge clk_i);
    pins_o.key_ok   = 1'b0;
    pins_o.key_up   = 1'b0;
    pins_o.key_stop = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask : press

  // enable off long enough to pass the two-flop sync, then on again
  task automatic toggle_enable();
    @(negedge clk_i);
    pins_o.drive_enable_cmd = 1'b0;
    repeat (6) @(negedge clk_i);
    pins_o.drive_enable_cmd = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask : toggle_enable

  // one-cycle reset request from the fieldbus side
  task automatic link_clear();
    @(negedge clk_i);
    bus_reset_o = 1'b1;
    @(negedge clk_i);
    bus_reset_o = 1'b0;
  endtask : link_clear
endmodule : dfa_partner

// ### dv/dfa_annunciator_test.sv
// Purpose: self-checking bench of the fault annunciator
// Assumes: lamp tick shortened to 10 clocks, so one tick is 10 cycles
// Notes:   lamps are sampled on the falling edge, where they are settled
`timescale 1ns/1ps
module dfa_annunciator_test;
  import dfa_pkg::*;
  localparam int TK = 10;

  logic       clk, rst_n, uv, cpu, defs, auto, run, relay, pmode, dflash, hview;
  mon_t       mon;
  pins_t      pins;
  logic       bus_rst;
  logic [2:0] hidx, kdp, dp_or;
  lamps_t     lamps;
  entry_t     fnum, hdat, kent;
  logic [7:0] fmb, hmb;
  int         err_count, num_checks, rises, max_on, max_dark;
  logic       red_sync, run_seen, st_low, fl_low, df_seen;
  logic [7:0] exp_mb [1:7] = '{8'h04, 8'h0B, 8'h06, 8'h03, 8'h08, 8'hF0, 8'hF1};
  entry_t     kp_exp [5]   = '{4'h7, 4'h6, 4'h5, 4'h4, 4'h4};
  logic [2:0] dp_exp [5]   = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h7};

  dfa_annunciator #(.TICK_CYCLES(TK)) dut (
    .clk_i(clk), .rst_n_i(rst_n), .mon_i(mon), .undervolt_i(uv), .cpu_fault_i(cpu),
    .pins_i(pins), .bus_reset_i(bus_rst), .defaults_restore_i(defs),
    .auto_restart_i(auto), .hist_idx_i(hidx), .drive_run_o(run), .relay_closed_o(relay),
    .lamps_o(lamps), .fault_num_o(fnum), .fault_mb_o(fmb), .hist_data_o(hdat),
    .hist_mb_o(hmb), .kp_param_mode_o(pmode), .kp_digit_flash_o(dflash),
    .kp_hist_view_o(hview), .kp_entry_o(kent), .kp_dp_o(kdp));

  dfa_partner p (.clk_i(clk), .pins_o(pins), .bus_reset_o(bus_rst));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  // history read has one cycle of latency
  task automatic rd(input int i);
    @(negedge clk);
    hidx = 3'(i);
    repeat (2) @(negedge clk);
  endtask : rd

  // bounded wait for a rising edge of the fault lamp, to align a burst window
  task automatic wait_rise();
    for (int k = 0; k < 400 && lamps.fault !== 1'b0; k++) @(negedge clk);
    for (int k = 0; k < 400 && lamps.fault !== 1'b1; k++) @(negedge clk);
  endtask : wait_rise

  // watch lamps and keypad for cyc clocks and gather pulse statistics
  task automatic scan(input int cyc);
    int on_n;
    int dk_n;
    logic prev;
    on_n = 0; dk_n = 0; prev = 1'b0; rises = 0; max_on = 0; max_dark = 0;
    red_sync = 1'b1; run_seen = 1'b0; st_low = 1'b0; fl_low = 1'b0;
    dp_or = '0; df_seen = 1'b0;
    repeat (cyc) begin
      if (lamps.fault === 1'b1 && !prev) rises++;
      prev = (lamps.fault === 1'b1);
      on_n = prev ? on_n + 1 : 0;
      dk_n = prev ? 0 : dk_n + 1;
      if (on_n > max_on) max_on = on_n;
      if (dk_n > max_dark) max_dark = dk_n;
      if (lamps.state !== lamps.fault) red_sync = 1'b0;
      if (lamps.run !== 1'b0) run_seen = 1'b1;
      if (lamps.state !== 1'b1) st_low = 1'b1;
      if (lamps.fault !== 1'b1) fl_low = 1'b1;
      if (dflash === 1'b1) df_seen = 1'b1;
      dp_or = dp_or | kdp;
      @(negedge clk);
    end
  endtask : scan

  // watchdog, far beyond the few thousand clocks the tests need
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    stop_test();
  end

  initial begin
    {mon, uv, cpu, defs, auto, hidx} = '0;
    rst_n = 1'b0;
    err_count = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    scan(3 * TK);
    chk("check red sync", 1, red_sync);
    chk("check run lamp", 0, run_seen);
    chk("check drive", 0, run);
    repeat (4 * TK) @(negedge clk);
    chk("steady enable run", 1, run);
    $display("test powerup done");

    // each fault code, cleared by enable toggle (codes 1 and 4), stop key, link clear or auto restart
    for (int n = 1; n <= 5; n++) begin
      mon = mon_t'(5'h10 >> (n - 1));
      repeat (3) @(negedge clk);
      chk("fault number", 8'(n), fnum);
      chk("fault link code", exp_mb[n], fmb);
      chk("relay open", 0, relay);
      chk("drive halted", 0, run);
      mon = 5'h1F;
      repeat (3) @(negedge clk);
      mon = '0;
      chk("second fault refused", 8'(n), fnum);
      repeat ((2 * n + 8) * TK) @(negedge clk);
      wait_rise();
      scan((2 * n + 8) * TK);
      chk("pulse count", 8'(n), rises);
      chk("pulse on time", 8'(TK), max_on);
      chk("burst pause", 1, max_dark >= 8 * TK);
      chk("state lamp steady", 0, st_low);
      chk("no self restart", 0, run);
      case (n)
        1, 4: p.toggle_enable();
        2: p.press(2, 6);
        3: p.link_clear();
        default: auto = 1'b1;
      endcase
      repeat (8) @(negedge clk);
      auto = 1'b0;
      chk("fault cleared", 0, fnum);
      chk("run resumed", 1, run);
      chk("relay closed", 1, relay);
    end
    $display("test fault codes done");

    for (int i = 0; i < 5; i++) begin
      rd(i);
      chk("history entry", 8'(5 - i), hdat);
      chk("history link code", exp_mb[5 - i], hmb);
    end
    $display("test history done");

    uv = 1'b1;
    repeat (3) @(negedge clk);
    scan(6 * TK);
    chk("uv red sync", 1, red_sync);
    chk("uv run lamp", 0, run_seen);
    chk("uv flashing", 1, rises > 1);
    uv = 1'b0;
    scan(3 * TK);
    chk("return red sync", 1, red_sync);
    chk("return run lamp", 0, run_seen);
    rd(0);
    chk("uv entry", 8'h6, hdat);
    chk("uv link code", exp_mb[6], hmb);
    defs = 1'b1;
    @(negedge clk) defs = 1'b0;
    rd(0);
    chk("defaults entry", 8'h7, hdat);
    chk("defaults link code", 8'hF1, hmb);
    rd(2);
    chk("history kept", 8'h5, hdat);
    $display("test undervoltage and defaults done");

    p.press(0, 4 * TK);
    chk("short hold", 0, pmode);
    p.press(0, 10 * TK);
    scan(3 * TK);
    chk("param mode", 1, pmode);
    chk("digit flash", 1, df_seen);
    p.press(0, 3);
    for (int i = 0; i < 5; i++) begin
      if (i > 0) p.press(1, 3);
      scan(3 * TK);
      chk("keypad entry", kp_exp[i], kent);
      chk("keypad points", dp_exp[i], dp_or);
    end
    p.press(2, 3);
    chk("view left", 0, hview);
    $display("test keypad done");

    cpu = 1'b1;
    repeat (3) @(negedge clk);
    scan(4 * TK);
    chk("cpu run lamp", 0, run_seen);
    chk("cpu state lamp", 0, st_low);
    chk("cpu fault lamp", 0, fl_low);
    cpu = 1'b0;
    mon = 5'h02;
    repeat (3) @(negedge clk);
    rst_n = 1'b0;
    mon = '0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("power cycle clear", 0, fnum);
    $display("test cpu and power cycle done");
    stop_test();
  end
endmodule : dfa_annunciator_test
